// File: udfc_bank.v
// Purpose: Unknown unicast / multicast forwarding control registers
// Assumes: Single-cycle register write strobe; read request sampled on the clock
// Notes: Read data and port masks come from flops; read data lags the request by one cycle
`timescale 1ns/100ps
`include "udfc_regs.vh"

module udfc_bank #(
    parameter PORTS = 4
) (
    input wire i_clk,
    input wire i_rst,
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire i_rd,
    output reg [7:0] o_rdata,
    output wire o_rvalid,
    output reg o_ucast_en,
    output reg [4:0] o_ucast_map,
    output reg o_mcast_en,
    output reg [4:0] o_mcast_map,
    output reg [1:0] o_drive_sel,
    output wire [PORTS-1:0] o_ucast_ports,
    output wire o_ucast_forward,
    output wire [PORTS-1:0] o_mcast_ports,
    output wire o_mcast_forward
);

    // Address match shared by the write strobes
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    function field_enable;
        input [7:0] data;
        begin
            field_enable = data[`UDFC_EN_BIT];
        end
    endfunction

    // Bit 0 is stored and read back but carries no meaning
    function [4:0] field_map;
        input [7:0] data;
        begin
            field_map = data[`UDFC_MAP_HI:`UDFC_MAP_LO];
        end
    endfunction

    function [1:0] field_drive;
        input [7:0] data;
        begin
            field_drive = data[`UDFC_DRIVE_HI:`UDFC_DRIVE_LO];
        end
    endfunction

    // Readback of a control byte
    // Upper field is zero for the unicast byte, whose top bits are reserved
    function [7:0] pack_ctrl;
        input [1:0] upper;
        input enable;
        input [4:0] map;
        begin
            pack_ctrl = 8'h00;
            pack_ctrl[`UDFC_DRIVE_HI:`UDFC_DRIVE_LO] = upper;
            pack_ctrl[`UDFC_EN_BIT] = enable;
            pack_ctrl[`UDFC_MAP_HI:`UDFC_MAP_LO] = map;
        end
    endfunction

    wire ucast_wr;
    wire mcast_wr;
    reg next_ucast_en;
    reg [4:0] next_ucast_map;
    reg next_mcast_en;
    reg [4:0] next_mcast_map;
    reg [1:0] next_drive_sel;
    reg [7:0] next_rdata;
    reg rvalid;
    wire [PORTS-1:0] next_ucast_ports;
    wire next_ucast_forward;
    wire [PORTS-1:0] next_mcast_ports;
    wire next_mcast_forward;
    reg [PORTS-1:0] ucast_ports;
    reg ucast_forward;
    reg [PORTS-1:0] mcast_ports;
    reg mcast_forward;

    // The reserved byte and unmapped offsets have no strobe, so writes there vanish
    assign ucast_wr = i_wr && addr_hit(i_addr, `UDFC_ADDR_UCAST);
    assign mcast_wr = i_wr && addr_hit(i_addr, `UDFC_ADDR_MCAST);

    always @* begin
        next_ucast_en = o_ucast_en;
        next_ucast_map = o_ucast_map;
        if (ucast_wr) begin
            next_ucast_en = field_enable(i_wdata);
            next_ucast_map = field_map(i_wdata);
        end
    end

    always @* begin
        next_mcast_en = o_mcast_en;
        next_mcast_map = o_mcast_map;
        if (mcast_wr) begin
            next_mcast_en = field_enable(i_wdata);
            next_mcast_map = field_map(i_wdata);
        end
    end

    always @* begin
        next_drive_sel = o_drive_sel;
        if (mcast_wr) begin
            next_drive_sel = field_drive(i_wdata);
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_ucast_en <= 1'b0;
            o_ucast_map <= `UDFC_MAP_RESET;
        end else begin
            o_ucast_en <= next_ucast_en;
            o_ucast_map <= next_ucast_map;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_mcast_en <= 1'b0;
            o_mcast_map <= `UDFC_MAP_RESET;
        end else begin
            o_mcast_en <= next_mcast_en;
            o_mcast_map <= next_mcast_map;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_drive_sel <= `UDFC_DRIVE_RESET;
        end else begin
            o_drive_sel <= next_drive_sel;
        end
    end

    // Decoding the next values lets the mask flops change in step with the maps
    // unicast map decode
    udfc_map_decode #(
        .PORTS(PORTS)
    ) u_ucast (
        .i_enable(next_ucast_en),
        .i_map(next_ucast_map),
        .o_ports(next_ucast_ports),
        .o_forward(next_ucast_forward)
    );

    udfc_map_decode #(
        .PORTS(PORTS)
    ) u_mcast (
        .i_enable(next_mcast_en),
        .i_map(next_mcast_map),
        .o_ports(next_mcast_ports),
        .o_forward(next_mcast_forward)
    );

    // Masks reach the forwarding engine from flops, never from the decode logic
    always @(posedge i_clk) begin
        if (i_rst) begin
            ucast_ports <= {PORTS{1'b0}};
            ucast_forward <= 1'b0;
            mcast_ports <= {PORTS{1'b0}};
            mcast_forward <= 1'b0;
        end else begin
            ucast_ports <= next_ucast_ports;
            ucast_forward <= next_ucast_forward;
            mcast_ports <= next_mcast_ports;
            mcast_forward <= next_mcast_forward;
        end
    end

    assign o_ucast_ports = ucast_ports;
    assign o_ucast_forward = ucast_forward;
    assign o_mcast_ports = mcast_ports;
    assign o_mcast_forward = mcast_forward;

    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `UDFC_ADDR_RSVD_LOW: next_rdata = `UDFC_RSVD_LOW_VALUE & `UDFC_RSVD_LOW_MASK;
            `UDFC_ADDR_UCAST: next_rdata = pack_ctrl(2'h0, o_ucast_en, o_ucast_map);
            `UDFC_ADDR_MCAST: next_rdata = pack_ctrl(o_drive_sel, o_mcast_en, o_mcast_map);
            default: next_rdata = 8'h00;
        endcase
    end

    // Flopped read data costs a cycle of latency but keeps the output glitch free
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= i_rd;
            // Last answer holds until the next read
            if (i_rd) begin
                o_rdata <= next_rdata;
            end
        end
    end

    assign o_rvalid = rvalid;

endmodule

// File: udfc_regs.vh
// Purpose: Register map constants for the unknown-destination forwarding control bank
// Assumes: 8-bit management register port, byte-wide data
// Notes: Offsets are the device register addresses
`ifndef UDFC_REGS_VH
`define UDFC_REGS_VH

`define UDFC_ADDR_RSVD_LOW 8'h82
`define UDFC_ADDR_UCAST 8'h83
`define UDFC_ADDR_MCAST 8'h84

`define UDFC_RSVD_LOW_VALUE 8'h04
`define UDFC_RSVD_LOW_MASK 8'h1F

`define UDFC_EN_BIT 5
`define UDFC_MAP_HI 4
`define UDFC_MAP_LO 0
`define UDFC_DRIVE_HI 7
`define UDFC_DRIVE_LO 6

`define UDFC_DRIVE_RESET 2'h1
`define UDFC_MAP_RESET 5'h00

`define UDFC_DRIVE_4MA 2'h0
`define UDFC_DRIVE_8MA 2'h1
`define UDFC_DRIVE_12MA 2'h2
`define UDFC_DRIVE_16MA 2'h3

`define UDFC_CODE_P1 4'h1
`define UDFC_CODE_P2 4'h2
`define UDFC_CODE_P12 4'h3
`define UDFC_CODE_ALL 4'hF

`endif

// File: udfc_map_decode.v
// Purpose: Turns a forwarding enable and port map into a port mask
// Assumes: Four switch ports, bit n of the mask is port n+1
// Notes: Undefined codes forward nowhere, the safe outcome
`timescale 1ns/100ps
`include "udfc_regs.vh"

module udfc_map_decode #(
    parameter PORTS = 4
) (
    input wire i_enable,
    input wire [4:0] i_map,
    output reg [PORTS-1:0] o_ports,
    output reg o_forward
);

    always @* begin
        o_ports = {PORTS{1'b0}};
        case (i_map[4:1])
            `UDFC_CODE_P1: o_ports[0] = 1'b1;
            `UDFC_CODE_P2: o_ports[1] = 1'b1;
            `UDFC_CODE_P12: o_ports[1:0] = 2'b11;
            `UDFC_CODE_ALL: o_ports = {PORTS{1'b1}};
            default: o_ports = {PORTS{1'b0}};
        endcase
        if (!i_enable) begin
            o_ports = {PORTS{1'b0}};
        end
        o_forward = |o_ports;
    end

endmodule

// File: udfc_bank_monitor.sv
// Purpose: Port checker for udfc_bank
// Assumes: One clock, sync reset
// Notes: Bound below
`timescale 1ns/100ps
module udfc_bank_chk #(parameter PORTS = 4) (
    input wire i_clk, input wire i_rst, input wire [7:0] i_addr, input wire i_wr, input wire [7:0] i_wdata,
    input wire i_rd, input wire o_rvalid,
    input wire [7:0] o_rdata, input wire o_ucast_en, input wire [4:0] o_ucast_map, input wire o_mcast_en,
    input wire [4:0] o_mcast_map, input wire [1:0] o_drive_sel, input wire [PORTS-1:0] o_ucast_ports,
    input wire o_ucast_forward, input wire [PORTS-1:0] o_mcast_ports
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_uen_write: assert property (i_wr && i_addr == 8'h83 |=> o_ucast_en == $past(i_wdata[5]))
        else $error("unicast enable write lost");
    a_umap_drop: assert property (o_ucast_map[4:1] == 4'h0 |-> o_ucast_ports == 0 && !o_ucast_forward)
        else $error("unicast zero map forwards");
    a_umap_decode: assert property (o_ucast_en && o_ucast_map[4:1] == 4'h3 |-> o_ucast_ports == 3)
        else $error("unicast map decode wrong");
    a_men_write: assert property (i_wr && i_addr == 8'h84 |=> o_mcast_en == $past(i_wdata[5]))
        else $error("multicast enable write lost");
    a_mmap_drop: assert property (o_mcast_map[4:1] == 4'h0 |-> o_mcast_ports == 0)
        else $error("multicast zero map forwards");
    a_mmap_decode: assert property (o_mcast_en && o_mcast_map[4:1] == 4'hf |-> o_mcast_ports == 4'hf)
        else $error("multicast map decode wrong");
    a_drive_write: assert property (i_wr && i_addr == 8'h84 |=> o_drive_sel == $past(i_wdata[7:6]))
        else $error("drive select write lost");
    a_rsvd_fixed: assert property (i_rd && i_addr == 8'h82 |=> o_rdata == 8'h04)
        else $error("reserved register changed");
    a_read_answer: assert property (i_rd |=> o_rvalid)
        else $error("read request not answered");
    cover property (o_ucast_forward);
    cover property (o_mcast_ports == 4'hf);
    cover property (i_wr && i_addr == 8'h82);
    cover property (i_rd ##1 o_rvalid);
endmodule
bind udfc_bank udfc_bank_chk #(.PORTS(PORTS)) chk_u (.*);

// File: testbench.sv
// Purpose: Self-checking bench for udfc_bank
// Assumes: Reads answer one cycle after the request is sampled
// Notes: Bits 7:6 of 0x83 read back as 0
`timescale 1ns/100ps
module testbench;
    logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
    logic [7:0] i_addr = 0, i_wdata = 0;
    wire [7:0] o_rdata;
    wire o_rvalid, o_ucast_en, o_mcast_en, o_ucast_forward, o_mcast_forward;
    wire [4:0] o_ucast_map, o_mcast_map;
    wire [1:0] o_drive_sel;
    wire [3:0] o_ucast_ports, o_mcast_ports;
    int mismatches = 0, checked = 0;
    logic [7:0] tc [6] = '{8'h22, 8'h25, 8'h26, 8'h3f, 8'h20, 8'h1e};
    logic [3:0] tp [6] = '{4'h1, 4'h2, 4'h3, 4'hf, 4'h0, 4'h0};
    udfc_bank dut_u (.*);
    initial forever #2 i_clk = ~i_clk;
    task chk(string n, logic [7:0] s, logic [7:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1;
        @(posedge i_clk);
        i_wr <= 0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1;
        @(posedge i_clk);
        chk("rvalid", o_rvalid, 0);
        @(posedge i_clk);
        chk("rdata", o_rdata, e);
        chk("rvalid", o_rvalid, 1);
        i_rd <= 0;
    endtask
    task summarize;
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 0;
        rd(8'h83, 0);
        chk("drive", o_drive_sel, 1);
        chk("uforward", o_ucast_forward, 0);
        chk("mports", o_mcast_ports, 0);
        rd(8'h84, 8'h40);
        wr(8'h82, 8'hc4);
        rd(8'h82, 8'h04);
        rd(8'h85, 0);
        for (int i = 0; i < 6; i++) begin
            wr(8'h83, tc[i] | 8'hc0);
            wr(8'h84, tc[i] | {i[1:0], 6'h0});
            rd(8'h83, tc[i]);
            rd(8'h84, tc[i] | {i[1:0], 6'h0});
            chk("uports", o_ucast_ports, tp[i]);
            chk("mports", o_mcast_ports, tp[i]);
            chk("uforward", o_ucast_forward, |tp[i]);
            chk("mforward", o_mcast_forward, |tp[i]);
            chk("mmap", o_mcast_map, tc[i][4:0]);
            chk("drive", o_drive_sel, i[1:0]);
        end
        wr(8'h84, 8'hff);
        @(posedge i_clk);
        i_rst <= 1;
        repeat (2) @(posedge i_clk);
        i_rst <= 0;
        rd(8'h83, 0);
        rd(8'h84, 8'h40);
        chk("mports", o_mcast_ports, 0);
        chk("drive", o_drive_sel, 1);
        summarize;
    end
    initial begin
        repeat (1000) @(posedge i_clk);
        mismatches++;
        summarize;
    end
endmodule
